/* File: dv/bcr_host_model.sv */
// host model: axi4-lite master issuing one transfer per go pulse
`timescale 1ns/1ps
module bcr_host_model (
  // clock and request
  input wire logic aclk,
  input wire logic go,
  input wire logic wr,
  // bus handshakes, responses and read data
  output logic awvalid = 1'b0,
  input wire logic awready,
  output logic wvalid = 1'b0,
  input wire logic wready,
  output logic bready = 1'b0,
  input wire logic bvalid,
  input wire logic [1:0] bresp,
  output logic arvalid = 1'b0,
  input wire logic arready,
  output logic rready = 1'b0,
  input wire logic rvalid,
  input wire logic [1:0] rresp,
  input wire logic [31:0] rdata,
  // result
  output logic done = 1'b0,
  output logic [1:0] resp = 2'h0,
  output logic [31:0] data = 32'h0
);
  // payload held by the bench until done; valids drop only at their own handshake
  always @(posedge aclk) begin
    done <= 1'b0;
    if (go && wr) begin
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end
    if (go && !wr) begin
      arvalid <= 1'b1;
      rready <= 1'b1;
    end
    if (awvalid && awready) awvalid <= 1'b0;
    if (wvalid && wready) wvalid <= 1'b0;
    if (bready && bvalid) begin
      bready <= 1'b0;
      resp <= bresp;
      done <= 1'b1;
    end
    if (arvalid && arready) arvalid <= 1'b0;
    if (rready && rvalid) begin
      rready <= 1'b0;
      resp <= rresp;
      data <= rdata;
      done <= 1'b1;
    end
  end
endmodule // bcr_host_model

/* File: dv/bcr_regs_properties.sv */
// checker for the breathing control register bank
`timescale 1ns/1ps
module bcr_regs_props (
  // clock, reset and enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // breathing controls
  input wire logic breath_mod_on,
  input wire logic breath_demod_on,
  input wire logic breath_mode_select,
  input wire logic breath_freq_select,
  input wire logic [3:0] breath_demod_phase,
  input wire logic breath_mod_clock,
  input wire logic breath_demod_clock
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // bus
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped before bready");
  rresp_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("rvalid dropped before rready");
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("arready high during read answer");
  write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write ready high during response");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready && ce |=> s_axi_rvalid)
    else $error("read answer late");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready && ce |=> ##1 s_axi_bvalid)
    else $error("write answer late");
  // ==========================================================
  // modulation
  fast_phase_a: assert property (breath_freq_select && !breath_mode_select ##1
    breath_freq_select && !breath_mode_select |-> !breath_demod_phase[3])
    else $error("phase top bit kept at fast clock");
  mod_idle_a: assert property ((!breath_mod_on || breath_mode_select) [*2]
    |-> !breath_mod_clock)
    else $error("modulation clock runs while off");
  demod_idle_a: assert property ((!breath_demod_on || breath_mode_select) [*2]
    |-> !breath_demod_clock)
    else $error("demodulation clock runs while off");
endmodule // bcr_regs_props

bind bcr_regs bcr_regs_props i_bcr_regs_props (.*);

/* File: dv/respiration_control_regs_test.sv */
// self-checking bench for the breathing control register bank
`timescale 1ns/1ps
module respiration_control_regs_test import bcr_pkg::*;;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic go = 1'b0;
  logic wr = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] strb = 4'hF;
  logic awv, awr, wv, wrd, bv, br, arv, arr, rv, rr, done;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, data;
  logic demod_on, mod_on, mode, freq, mclk, dclk, cal, ref_int;
  logic [3:0] phase;
  logic [15:0] cdeg;
  int err_count = 0;
  int check_count = 0;
  initial forever #12.5 aclk = ~aclk;
  bcr_regs i_bcr_regs (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .s_axi_awaddr(addr), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(addr), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .breath_demod_on(demod_on), .breath_mod_on(mod_on), .breath_demod_phase(phase),
    .breath_phase_centideg(cdeg), .breath_mode_select(mode), .breath_freq_select(freq),
    .breath_mod_clock(mclk), .breath_demod_clock(dclk), .offset_cal_enable(cal),
    .drive_ref_internal(ref_int));
  bcr_host_model i_bcr_host_model (.aclk(aclk), .go(go), .wr(wr), .awvalid(awv),
    .awready(awr), .wvalid(wv), .wready(wrd), .bready(br), .bvalid(bv), .bresp(bresp),
    .arvalid(arv), .arready(arr), .rready(rr), .rvalid(rv), .rresp(rresp), .rdata(rdata),
    .done(done), .resp(resp), .data(data));
  // ==========================================================
  // helpers
  task automatic print_verdict();
    if (err_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic bus(logic w, logic [7:0] a, logic [7:0] d);
    int n;
    @(posedge aclk);
    wr <= w;
    addr <= a;
    wdata <= {24'h0, d};
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    for (n = 0; n < 50 && done !== 1'b1; n++) @(negedge aclk);
    if (n == 50) begin
      err_count++;
      print_verdict();
    end
  endtask
  task automatic period(logic [10:0] exp, logic [10:0] lag);
    int n;
    int t;
    for (n = 0; n < 3000 && mclk !== 1'b0; n++) @(negedge aclk);
    for (n = 0; n < 3000 && mclk !== 1'b1; n++) @(negedge aclk);
    for (t = 0; t < 3000 && mclk !== 1'b0; t++) @(negedge aclk);
    for (n = t; n < 3000 && mclk !== 1'b1; n++) @(negedge aclk);
    chk("mod period", 32'(exp), 32'(n));
    // demod edge trails the mod edge by the phase offset in cycles
    for (n = 0; n < 3000 && mclk !== 1'b0; n++) @(negedge aclk);
    for (n = 0; n < 3000 && mclk !== 1'b1; n++) @(negedge aclk);
    for (n = 0; n < 3000 && dclk !== 1'b1; n++) @(negedge aclk);
    chk("demod lag", 32'(lag), 32'(n));
  endtask
  // ==========================================================
  // scenarios
  task automatic reset_values();
    bus(0, BCR_IDX_PRIMARY << 2, 8'h00);
    chk("primary reset", 32'h02, data);
    bus(0, BCR_IDX_SECONDARY << 2, 8'h00);
    chk("secondary reset", 32'h03, data);
    chk("outputs reset", 32'h01, {demod_on, mod_on, cal, ref_int});
  endtask
  task automatic phase_table();
    for (int f = 0; f < 2; f++) begin
      bus(1, BCR_IDX_SECONDARY << 2, f ? 8'h85 : 8'h03);
      chk("secondary fields", f ? 32'h6 : 32'h1, {cal, freq, ref_int});
      for (int c = 0; c < (f ? 8 : 16); c++) begin
        bus(1, BCR_IDX_PRIMARY << 2, 8'hC2 | 8'(c << 2));
        chk("phase code", f ? 32'(c & 7) : 32'(c), 32'(phase));
        chk("phase cdeg", f ? 32'((c & 7) * 2250) : 32'(c * 1125), 32'(cdeg));
        chk("enables", 32'h3, {demod_on, mod_on});
        bus(0, BCR_IDX_PRIMARY << 2, 8'h00);
        chk("primary readback", 32'hC2 | 32'(c << 2), data);
      end
      period(f ? 11'd625 : 11'd1250, f ? 11'd273 : 11'd585);
    end
  endtask
  task automatic external_mode();
    bus(1, BCR_IDX_PRIMARY << 2, 8'hC3);
    repeat (1300) begin
      @(negedge aclk);
      if (mclk !== 1'b0) chk("idle mod clock", 32'h0, 32'(mclk));
    end
    chk("mode bit", 32'h1, 32'(mode));
    bus(1, BCR_IDX_PRIMARY << 2, 8'h02);
    chk("enables off", 32'h0, {demod_on, mod_on});
  endtask
  task automatic unmapped();
    bus(1, 8'h30, 8'hFF);
    chk("unmapped bresp", 32'(BCR_RESP_SLVERR), 32'(resp));
    bus(0, 8'h30, 8'h00);
    chk("unmapped rresp", 32'(BCR_RESP_SLVERR), 32'(resp));
    chk("unmapped rdata", BCR_RDATA_ZERO, data);
    strb <= 4'h0;
    bus(1, BCR_IDX_SECONDARY << 2, 8'h05);
    chk("no strobe bresp", 32'(BCR_RESP_OKAY), 32'(resp));
    strb <= 4'hF;
    bus(0, BCR_IDX_SECONDARY << 2, 8'h00);
    chk("secondary kept", 32'h85, data);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    reset_values();
    phase_table();
    external_mode();
    unmapped();
    print_verdict();
  end
endmodule // respiration_control_regs_test

/* File: shared/bcr_pkg.sv */
// constants for the breathing control register bank
package bcr_pkg;
  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [7:0] BCR_IDX_PRIMARY = 8'h09;
  localparam logic [7:0] BCR_IDX_SECONDARY = 8'h0A;
  localparam int BCR_IDX_SHIFT = 2;
  // ==========================================================
  // reset values
  localparam logic [7:0] BCR_PRIMARY_RST = 8'h02;
  localparam logic [7:0] BCR_SECONDARY_RST = 8'h03;
  // ==========================================================
  // primary field positions
  localparam int BCR_DEMOD_ON_BIT = 7;
  localparam int BCR_MOD_ON_BIT = 6;
  localparam int BCR_PHASE_HI = 5;
  localparam int BCR_PHASE_LO = 2;
  localparam int BCR_MODE_BIT = 0;
  // ==========================================================
  // secondary field positions
  localparam int BCR_CAL_BIT = 7;
  localparam int BCR_FREQ_BIT = 2;
  localparam int BCR_REF_BIT = 1;
  // ==========================================================
  // phase code handling
  localparam int BCR_PHASE_W = 4;
  localparam logic [3:0] BCR_FAST_PHASE_MASK = 4'h7;
  localparam int BCR_STEP_SHIFT_SLOW = 5;
  localparam int BCR_STEP_SHIFT_FAST = 4;
  localparam logic [15:0] BCR_CDEG_STEP_SLOW = 16'h0465;
  localparam logic [15:0] BCR_CDEG_STEP_FAST = 16'h08CA;
  // ==========================================================
  // modulation clock timing
  localparam int BCR_CLK_HZ = 40_000_000;
  localparam int BCR_MOD_SLOW_HZ = 32_000;
  localparam int BCR_MOD_FAST_HZ = 64_000;
  localparam int BCR_CNT_W = 11;
  localparam logic [10:0] BCR_PERIOD_SLOW = 11'(BCR_CLK_HZ / BCR_MOD_SLOW_HZ);
  localparam logic [10:0] BCR_PERIOD_FAST = 11'(BCR_CLK_HZ / BCR_MOD_FAST_HZ);
  localparam logic [10:0] BCR_CNT_ONE = 11'h001;
  localparam logic [10:0] BCR_CNT_ZERO = 11'h000;
  // ==========================================================
  // bus responses
  localparam logic [1:0] BCR_RESP_OKAY = 2'h0;
  localparam logic [1:0] BCR_RESP_SLVERR = 2'h2;
  localparam logic [31:0] BCR_RDATA_ZERO = 32'h0000_0000;
endpackage

/* File: verilog/bcr_regs.sv */
// breathing control register bank with axi4-lite slave and modulation clocks
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
// ==========================================================
// How it works
// - primary bit 7 turns channel-one demodulation on; off after reset.
// - primary bit 6 turns channel-one modulation on; off after reset.
// - phase code bits 5..2 shift demodulation 11.25 degrees per step at 32 kHz.
// - at 64 kHz phase code top bit ignored; 22.5 degree steps, max 157.5.
// - primary bit 0 low selects internal breathing mode with internal clock.
// - in internal mode freq bit picks 32 kHz (0) or 64 kHz (1).
// - secondary bit 7 turns offset calibration on; off after reset.
// - secondary bit 1 low selects external drive reference, high internal.
module bcr_regs import bcr_pkg::*; #(
  parameter int ADDR_W = 8
) (
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // breathing controls
  output logic breath_demod_on,
  output logic breath_mod_on,
  output logic [3:0] breath_demod_phase,
  output logic [15:0] breath_phase_centideg,
  output logic breath_mode_select,
  output logic breath_freq_select,
  output logic breath_mod_clock,
  output logic breath_demod_clock,
  output logic offset_cal_enable,
  output logic drive_ref_internal
);

  // ==========================================================
  // helpers
  typedef enum logic [1:0] {
    BCR_SEL_NONE,
    BCR_SEL_PRIMARY,
    BCR_SEL_SECONDARY
  } bcr_sel_t;

  function automatic bcr_sel_t reg_sel(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] idx;
    idx = addr >> BCR_IDX_SHIFT;
    if (idx == ADDR_W'(BCR_IDX_PRIMARY)) begin
      return BCR_SEL_PRIMARY;
    end else if (idx == ADDR_W'(BCR_IDX_SECONDARY)) begin
      return BCR_SEL_SECONDARY;
    end
    return BCR_SEL_NONE;
  endfunction

  function automatic logic [10:0] mod_period(input logic fast);
    return fast ? BCR_PERIOD_FAST : BCR_PERIOD_SLOW;
  endfunction

  // ==========================================================
  // register state
  logic [7:0] primary_reg;
  logic [7:0] secondary_reg;
  logic aw_hold_reg;
  logic w_hold_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [7:0] wdata_reg;
  logic wstrb0_reg;
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  logic commit;
  bcr_sel_t wsel;
  bcr_sel_t rsel;
  assign commit = aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign wsel = reg_sel(awaddr_reg);
  assign rsel = reg_sel(s_axi_araddr);

  // ==========================================================
  // write address and data capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      awaddr_reg <= '0;
      awready_reg <= 1'b0;
    end else if (ce) begin
      if (s_axi_awvalid && awready_reg) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
        awready_reg <= 1'b0;
      end else if (commit) begin
        aw_hold_reg <= 1'b0;
      end else if (!aw_hold_reg && !bvalid_reg) begin
        awready_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_reg <= 1'b0;
      wdata_reg <= '0;
      wstrb0_reg <= 1'b0;
      wready_reg <= 1'b0;
    end else if (ce) begin
      if (s_axi_wvalid && wready_reg) begin
        w_hold_reg <= 1'b1;
        wdata_reg <= s_axi_wdata[7:0];
        wstrb0_reg <= s_axi_wstrb[0];
        wready_reg <= 1'b0;
      end else if (commit) begin
        w_hold_reg <= 1'b0;
      end else if (!w_hold_reg && !bvalid_reg) begin
        wready_reg <= 1'b1;
      end
    end
  end

  // ==========================================================
  // register write and response
  // whole byte is stored so fixed bits read back as written
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      primary_reg <= BCR_PRIMARY_RST;
      secondary_reg <= BCR_SECONDARY_RST;
    end else if (ce && commit && wstrb0_reg) begin
      if (wsel == BCR_SEL_PRIMARY) begin
        primary_reg <= wdata_reg;
      end else if (wsel == BCR_SEL_SECONDARY) begin
        secondary_reg <= wdata_reg;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= BCR_RESP_OKAY;
    end else if (ce) begin
      if (commit) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= (wsel == BCR_SEL_NONE) ? BCR_RESP_SLVERR : BCR_RESP_OKAY;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= BCR_RDATA_ZERO;
      rresp_reg <= BCR_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && arready_reg) begin
        arready_reg <= 1'b0;
        rvalid_reg <= 1'b1;
        unique case (rsel)
          BCR_SEL_PRIMARY: begin
            rdata_reg <= {24'h000000, primary_reg};
            rresp_reg <= BCR_RESP_OKAY;
          end
          BCR_SEL_SECONDARY: begin
            rdata_reg <= {24'h000000, secondary_reg};
            rresp_reg <= BCR_RESP_OKAY;
          end
          default: begin
            rdata_reg <= BCR_RDATA_ZERO;
            rresp_reg <= BCR_RESP_SLVERR;
          end
        endcase
      end else if (rvalid_reg && s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end else if (!rvalid_reg) begin
        arready_reg <= 1'b1;
      end
    end
  end

  // ==========================================================
  // field decode
  logic internal_mode;
  logic fast;
  logic [3:0] eff_code;
  assign internal_mode = !primary_reg[BCR_MODE_BIT];
  assign fast = internal_mode && secondary_reg[BCR_FREQ_BIT];
  // top phase bit has no meaning at the fast rate
  assign eff_code = fast ? (primary_reg[BCR_PHASE_HI:BCR_PHASE_LO] & BCR_FAST_PHASE_MASK)
                         : primary_reg[BCR_PHASE_HI:BCR_PHASE_LO];

  // ==========================================================
  // modulation counter and phase-shifted demodulation reference
  logic [10:0] cnt_reg;
  logic [10:0] period;
  logic [10:0] half;
  logic [10:0] ofs;
  logic [14:0] prod;
  logic [10:0] shifted;
  assign period = mod_period(fast);
  assign half = period >> 1;
  assign prod = 15'(eff_code) * 15'(period);
  assign ofs = fast ? 11'(prod >> BCR_STEP_SHIFT_FAST)
                    : 11'(prod >> BCR_STEP_SHIFT_SLOW);
  assign shifted = (cnt_reg >= ofs) ? (cnt_reg - ofs) : 11'(cnt_reg + period - ofs);

  // external mode leaves the internal generator idle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= BCR_CNT_ZERO;
    end else if (ce) begin
      if (!internal_mode || cnt_reg >= period - BCR_CNT_ONE) begin
        cnt_reg <= BCR_CNT_ZERO;
      end else begin
        cnt_reg <= cnt_reg + BCR_CNT_ONE;
      end
    end
  end

  logic mod_clk_reg;
  logic demod_clk_reg;
  logic [3:0] phase_reg;
  logic [15:0] cdeg_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mod_clk_reg <= 1'b0;
      demod_clk_reg <= 1'b0;
      phase_reg <= '0;
      cdeg_reg <= '0;
    end else if (ce) begin
      mod_clk_reg <= internal_mode && primary_reg[BCR_MOD_ON_BIT]
                     && (cnt_reg < half);
      demod_clk_reg <= internal_mode && primary_reg[BCR_DEMOD_ON_BIT]
                       && (shifted < half);
      phase_reg <= eff_code;
      cdeg_reg <= 16'(eff_code) * (fast ? BCR_CDEG_STEP_FAST : BCR_CDEG_STEP_SLOW);
    end
  end

  // ==========================================================
  // outputs
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign breath_demod_on = primary_reg[BCR_DEMOD_ON_BIT];
  assign breath_mod_on = primary_reg[BCR_MOD_ON_BIT];
  assign breath_demod_phase = phase_reg;
  assign breath_phase_centideg = cdeg_reg;
  assign breath_mode_select = primary_reg[BCR_MODE_BIT];
  assign breath_freq_select = secondary_reg[BCR_FREQ_BIT];
  assign breath_mod_clock = mod_clk_reg;
  assign breath_demod_clock = demod_clk_reg;
  assign offset_cal_enable = secondary_reg[BCR_CAL_BIT];
  assign drive_ref_internal = secondary_reg[BCR_REF_BIT];

endmodule // bcr_regs
